// *** hw/xmem_pkg.sv ***
// Purpose: Shared constants and types for the external data memory port
// Assumes: One system clock; special function registers on an 8-bit port
// Notes:   Register offsets, field positions and reset values live here
package xmem_pkg;

  // ---------------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] TIMING_ADDR  = 8'hA1;
  localparam logic [7:0] PAGE_ADDR    = 8'hA2;
  localparam logic [7:0] CONFIG_ADDR  = 8'hA3;
  localparam logic [7:0] TIMING_RESET = 8'hFF;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h03;
  localparam logic [7:0] CONFIG_MASK  = 8'h3F;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int PORT_GROUP_BIT = 5;
  localparam int MULTIPLEX_BIT  = 4;
  localparam int MODE_HI        = 3;
  localparam int MODE_LO        = 2;
  localparam int LATCH_HI       = 1;
  localparam int LATCH_LO       = 0;
  localparam int SETUP_HI       = 7;
  localparam int SETUP_LO       = 6;
  localparam int WIDTH_HI       = 5;
  localparam int WIDTH_LO       = 2;
  localparam int HOLD_HI        = 1;
  localparam int HOLD_LO        = 0;

  // ---------------------------------------------------------------------
  // Memory size and sequencing counts
  // ---------------------------------------------------------------------
  localparam int          ONCHIP_BYTES = 4096;
  localparam int          ONCHIP_AW    = 12;
  localparam logic [15:0] ONCHIP_LIMIT = 16'h1000;
  localparam int          START_CYCLES = 1;
  localparam int          OVERHEAD     = 4;
  localparam logic [3:0]  TAIL_LOAD    = 4'(OVERHEAD - START_CYCLES - 1);
  localparam logic [3:0]  COUNT_ZERO   = 4'h0;
  localparam logic [1:0]  FIELD_ZERO   = 2'h0;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ONCHIP       = 2'b00,
    MODE_SPLIT_NOBANK = 2'b01,
    MODE_SPLIT_BANK   = 2'b10,
    MODE_OFFCHIP      = 2'b11
  } space_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'b0000,
    ST_ONCHIP     = 4'b0001,
    ST_ONCHIP_FIN = 4'b0010,
    ST_START      = 4'b0011,
    ST_ALE_H      = 4'b0100,
    ST_ALE_L      = 4'b0101,
    ST_SETUP      = 4'b0110,
    ST_STROBE     = 4'b0111,
    ST_HOLD       = 4'b1000,
    ST_TAIL       = 4'b1001
  } state_t;

  typedef struct packed {
    logic        write;
    logic        wide;
    logic [7:0]  index_low;
    logic [15:0] pointer16;
    logic [7:0]  wdata;
  } move_req_t;

  // Pin values, and the same layout reused for active-low enables
  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] ad;
    logic [7:0] data;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
  } pins_t;

  typedef struct packed {
    logic [7:0] ad;
    logic [7:0] data;
  } pins_in_t;

endpackage

// *** hw/onchip_ram.sv ***
// Purpose: On-chip data RAM, one synchronous port
// Assumes: Read data appears one clock after the enabled access
// Notes:   No reset on the array; output register resets to zero
`timescale 1ns/1ps
`default_nettype none
module onchip_ram
  import xmem_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 enable,
  input  wire logic                 write,
  input  wire logic [ONCHIP_AW-1:0] addr,
  input  wire logic [7:0]           wdata,
  output var  logic [7:0]           rdata
);

  logic [7:0] mem [ONCHIP_BYTES];

  // Array write
  always_ff @(posedge clock)
  begin
    if (enable && write)
      mem[addr] <= wdata;
  end

  // Registered read
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (enable && !write)
      rdata <= mem[addr];
  end

endmodule // onchip_ram
`default_nettype wire

// *** hw/external_data_memory_port.sv ***
// Purpose: Address generation, on/off-chip steering and bus sequencing
// Assumes: CPU presents one external move at a time while not busy
// Notes:   Pin enables are active low; high means pin left to port latch
// Operation
// - Narrow moves take the upper address byte from the page register.
// - Port-select bit clear puts bus on low group, set on high.
// - Multiplex bit clear shares low address and data; set separates them.
// - Mode 00 sends all moves on-chip, address folded modulo 4k.
// - Narrow address is page plus index; wide address is the pointer.
// - Split modes send addresses below 4k on-chip, others off-chip.
// - Split without bank: narrow off-chip drives only address bits 7:0.
// - Split with bank: narrow off-chip drives all sixteen address bits.
// - Wide moves in split modes steer by pointer; off-chip drives 16 bits.
// - Mode 11 sends all off-chip; narrow leaves bits 15:8 undriven.
// - Multiplexed: address on AD while latch strobe high, then data.
// - Non-multiplexed: separate address and data pins, no latch strobe.
// - Two-bit field sets latch strobe high and low time, 1 to 4.
// - Off-chip move lasts setup, strobe, hold plus four clocks.
// - Multiplexed adds at least two latch strobe clocks, seven minimum.
// - Setup and hold settings reset to their largest values.
// - Configuration bits 7 and 6 read zero and ignore writes.
// - Bus pins are claimed only during an off-chip move.
// - Pins acting as inputs have drivers switched off during a move.
// - Setup and hold fields give 0 to 3 clocks directly.
// - Four-bit field gives strobe width of field plus one clocks.
`timescale 1ns/1ps
`default_nettype none
module external_data_memory_port
  import xmem_pkg::*;
(
  input  wire logic                     CLOCK,
  input  wire logic                     SYS_RST,
  input  wire logic [7:0]               SFR_ADDR,
  input  wire logic                     SFR_WRITE,
  input  wire logic [7:0]               SFR_WDATA,
  output var  logic [7:0]               SFR_RDATA,
  input  wire logic                     MOVE_VALID,
  input  wire xmem_pkg::move_req_t      MOVE_REQ,
  output var  logic                     MOVE_BUSY,
  output var  logic                     MOVE_DONE,
  output var  logic [7:0]               MOVE_RDATA,
  input  wire xmem_pkg::pins_in_t [1:0] GROUP_IN,
  output var  xmem_pkg::pins_t    [1:0] GROUP_OUT,
  output var  xmem_pkg::pins_t    [1:0] GROUP_OE_N
);
  import xmem_pkg::*;

  // ---------------------------------------------------------------------
  // Steering decision
  // ---------------------------------------------------------------------
  function automatic logic route_onchip(input space_mode_t mode,
                                        input logic [15:0] eff);
    logic below;
    below = (eff < ONCHIP_LIMIT);
    unique case (mode)
      MODE_ONCHIP:       route_onchip = 1'b1;
      MODE_SPLIT_NOBANK: route_onchip = below;
      MODE_SPLIT_BANK:   route_onchip = below;
      MODE_OFFCHIP:      route_onchip = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------------
  logic [7:0]  page_high_byte;
  logic [7:0]  memory_port_config;
  logic [7:0]  memory_timing_control;
  state_t      state;
  state_t      next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [15:0] acc_addr;
  logic        acc_write;
  logic [7:0]  acc_wdata;
  logic        acc_mux;
  logic        acc_group;
  logic        acc_drive_hi;
  pins_t       pin_val;
  pins_t       pin_oe_n;
  pins_t       next_pin_val;
  pins_t       next_pin_oe_n;
  logic [7:0]  ram_q;

  // ---------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------
  wire space_mode_t space_mode_field =
    space_mode_t'(memory_port_config[MODE_HI:MODE_LO]);
  wire logic       port_group_choice    = memory_port_config[PORT_GROUP_BIT];
  wire logic       bus_multiplex_choice = memory_port_config[MULTIPLEX_BIT];
  wire logic [1:0] latch_strobe_width   =
    memory_port_config[LATCH_HI:LATCH_LO];
  wire logic [1:0] addr_setup_field     =
    memory_timing_control[SETUP_HI:SETUP_LO];
  wire logic [3:0] strobe_width_field   =
    memory_timing_control[WIDTH_HI:WIDTH_LO];
  wire logic [1:0] addr_hold_field      =
    memory_timing_control[HOLD_HI:HOLD_LO];

  // ---------------------------------------------------------------------
  // Request intake and address forming
  // ---------------------------------------------------------------------
  wire logic take = MOVE_VALID && (state == ST_IDLE);
  wire logic [15:0] eff_addr = MOVE_REQ.wide ? MOVE_REQ.pointer16
                             : {page_high_byte, MOVE_REQ.index_low};
  wire logic eff_onchip = route_onchip(space_mode_field, eff_addr);
  wire logic eff_drive_hi = MOVE_REQ.wide
                         || (space_mode_field == MODE_SPLIT_BANK);

  // Live view of the access, fresh on the taking cycle
  wire logic [15:0] cur_addr  = take ? eff_addr : acc_addr;
  wire logic        cur_write = take ? MOVE_REQ.write : acc_write;
  wire logic [7:0]  cur_wdata = take ? MOVE_REQ.wdata : acc_wdata;
  wire logic        cur_mux   = take ? !bus_multiplex_choice : acc_mux;
  wire logic        cur_hi    = take ? eff_drive_hi : acc_drive_hi;

  // ---------------------------------------------------------------------
  // Phase lengths
  // ---------------------------------------------------------------------
  // latch strobe 1 to 4 clocks
  wire logic [3:0] latch_load = {2'b00, latch_strobe_width};
  wire logic [3:0] width_load = strobe_width_field;
  wire logic       setup_zero  = (addr_setup_field == FIELD_ZERO);
  wire state_t     setup_state = setup_zero ? ST_STROBE : ST_SETUP;
  wire logic [3:0] setup_load  = setup_zero ? width_load
                               : {2'b00, addr_setup_field - 2'd1};
  wire logic       hold_zero  = (addr_hold_field == FIELD_ZERO);
  wire state_t     hold_state = hold_zero ? ST_TAIL : ST_HOLD;
  wire logic [3:0] hold_load  = hold_zero ? TAIL_LOAD
                              : {2'b00, addr_hold_field - 2'd1};
  wire logic       phase_end  = (cnt == COUNT_ZERO);

  // ---------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------
  // start and tail add four
  always_comb
  begin
    next_state = state;
    next_cnt   = phase_end ? COUNT_ZERO : cnt - 4'd1;
    unique case (state)
      ST_IDLE:
        if (take)
        begin
          next_state = eff_onchip ? ST_ONCHIP : ST_START;
          next_cnt   = COUNT_ZERO;
        end
      ST_ONCHIP:
        next_state = ST_ONCHIP_FIN;
      ST_ONCHIP_FIN:
        next_state = ST_IDLE;
      ST_START:
        if (acc_mux)
        begin
          next_state = ST_ALE_H;
          next_cnt   = latch_load;
        end
        else
        begin
          next_state = setup_state;
          next_cnt   = setup_load;
        end
      ST_ALE_H:
        if (phase_end)
        begin
          next_state = ST_ALE_L;
          next_cnt   = latch_load;
        end
      ST_ALE_L:
        if (phase_end)
        begin
          next_state = setup_state;
          next_cnt   = setup_load;
        end
      ST_SETUP:
        if (phase_end)
        begin
          next_state = ST_STROBE;
          next_cnt   = width_load;
        end
      ST_STROBE:
        if (phase_end)
        begin
          next_state = hold_state;
          next_cnt   = hold_load;
        end
      ST_HOLD:
        if (phase_end)
        begin
          next_state = ST_TAIL;
          next_cnt   = TAIL_LOAD;
        end
      ST_TAIL:
        if (phase_end)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // Pin drive for the coming cycle
  // ---------------------------------------------------------------------
  // claim pins only off-chip
  wire logic ext     = (next_state >= ST_START);
  wire logic addr_ph = (next_state == ST_START) || (next_state == ST_ALE_H);
  wire logic strobe  = (next_state == ST_STROBE);
  always_comb
  begin
    next_pin_val.addr_hi = cur_addr[15:8];
    next_pin_oe_n.addr_hi = {8{!(ext && cur_hi)}};
    next_pin_val.ad = (cur_mux && !addr_ph) ? cur_wdata : cur_addr[7:0];
    next_pin_oe_n.ad = {8{!(ext && (!cur_mux || addr_ph || cur_write))}};
    next_pin_val.data = cur_wdata;
    next_pin_oe_n.data = {8{!(ext && !cur_mux && cur_write)}};
    next_pin_val.ale = (next_state == ST_ALE_H);
    next_pin_oe_n.ale = !(ext && cur_mux);
    next_pin_val.rd_n = !(strobe && !cur_write);
    next_pin_val.wr_n = !(strobe && cur_write);
    next_pin_oe_n.rd_n = !ext;
    next_pin_oe_n.wr_n = !ext;
  end

  // ---------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------
  // setup and hold reset high
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      page_high_byte        <= PAGE_RESET;
      memory_port_config    <= CONFIG_RESET;
      memory_timing_control <= TIMING_RESET;
    end
    else if (SFR_WRITE)
    begin
      if (SFR_ADDR == PAGE_ADDR)
        page_high_byte <= SFR_WDATA;
      if (SFR_ADDR == CONFIG_ADDR)
        memory_port_config <= SFR_WDATA & CONFIG_MASK;
      if (SFR_ADDR == TIMING_ADDR)
        memory_timing_control <= SFR_WDATA;
    end
  end

  // Read mux; unmapped offsets read zero
  assign SFR_RDATA = (SFR_ADDR == PAGE_ADDR)   ? page_high_byte
                   : (SFR_ADDR == CONFIG_ADDR) ? memory_port_config
                   : (SFR_ADDR == TIMING_ADDR) ? memory_timing_control
                   : 8'h00;

  // ---------------------------------------------------------------------
  // Sequencer and access latch
  // ---------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      state        <= ST_IDLE;
      cnt          <= COUNT_ZERO;
      acc_addr     <= 16'h0000;
      acc_write    <= 1'b0;
      acc_wdata    <= 8'h00;
      acc_mux      <= 1'b0;
      acc_group    <= 1'b0;
      acc_drive_hi <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take)
      begin
        acc_addr     <= eff_addr;
        acc_write    <= MOVE_REQ.write;
        acc_wdata    <= MOVE_REQ.wdata;
        acc_mux      <= !bus_multiplex_choice;
        acc_group    <= port_group_choice;
        acc_drive_hi <= eff_drive_hi;
      end
    end
  end

  // Registered pin drive, released after reset
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      pin_val  <= '1;
      pin_oe_n <= '1;
    end
    else
    begin
      pin_val  <= next_pin_val;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ---------------------------------------------------------------------
  // Completion and read data
  // ---------------------------------------------------------------------
  wire pins_in_t   sel_in   = GROUP_IN[acc_group];
  wire logic [7:0] ext_data = acc_mux ? sel_in.ad : sel_in.data;
  wire logic       ext_cap  = (state == ST_STROBE) && phase_end && !acc_write;
  wire logic       ram_cap  = (state == ST_ONCHIP_FIN) && !acc_write;
  wire logic       finish   = (state == ST_ONCHIP_FIN)
                           || ((state == ST_TAIL) && phase_end);
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      MOVE_DONE  <= 1'b0;
      MOVE_RDATA <= 8'h00;
    end
    else
    begin
      MOVE_DONE <= finish;
      if (ext_cap)
        MOVE_RDATA <= ext_data;
      else if (ram_cap)
        MOVE_RDATA <= ram_q;
    end
  end

  assign MOVE_BUSY = (state != ST_IDLE);

  // ---------------------------------------------------------------------
  // Port group routing
  // ---------------------------------------------------------------------
  // only chosen group claimed
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_group
      assign GROUP_OUT[g]  = pin_val;
      assign GROUP_OE_N[g] = (acc_group == 1'(g)) ? pin_oe_n : '1;
    end
  endgenerate

  // ---------------------------------------------------------------------
  // On-chip RAM
  // ---------------------------------------------------------------------
  // low twelve bits fold the space
  onchip_ram onchip_ram_inst (
    .clock   (CLOCK),
    .sys_rst (SYS_RST),
    .enable  (state == ST_ONCHIP),
    .write   (acc_write),
    .addr    (acc_addr[ONCHIP_AW-1:0]),
    .wdata   (acc_wdata),
    .rdata   (ram_q)
  );

endmodule // external_data_memory_port
`default_nettype wire

// *** tb/xmem_sram.sv ***
// Purpose: Behavioural external SRAM with address latch on one group
// Assumes: Undriven port pins park at ones; data lines have pull-ups
// Notes:   RD_LAT delays read data; before that the inverse is shown
`timescale 1ns/1ps
`default_nettype none
module xmem_sram
  import xmem_pkg::*;
#(
  parameter int RD_LAT = 0
)
(
  input  wire logic               clock,
  input  wire logic               mux,
  input  wire xmem_pkg::pins_t    pin,
  input  wire xmem_pkg::pins_t    oe_n,
  output var  xmem_pkg::pins_in_t drv
);
  logic [7:0]  mem [logic [15:0]];
  logic [7:0]  low_latch;
  logic [7:0]  rval;
  logic [15:0] addr;
  int          rd_cnt;

  always_latch
    if (pin.ale | oe_n.ale)
      low_latch <= pin.ad | oe_n.ad;

  // Undriven upper lines read as the parked latch level
  assign addr = {pin.addr_hi | oe_n.addr_hi,
                 mux ? low_latch : (pin.ad | oe_n.ad)};

  // Store on write strobe, answer on read strobe, else release lines
  always @(negedge clock)
  begin
    drv <= '1;
    rd_cnt <= 0;
    if (!pin.wr_n && !oe_n.wr_n)
      mem[addr] = mux ? pin.ad : pin.data;
    if (!pin.rd_n && !oe_n.rd_n)
    begin
      rd_cnt <= rd_cnt + 1;
      rval = mem.exists(addr) ? mem[addr] : 8'h00;
      rval = (rd_cnt >= RD_LAT) ? rval : ~rval;
      if (mux)
        drv.ad <= rval;
      else
        drv.data <= rval;
    end
  end
endmodule // xmem_sram
`default_nettype wire

// *** tb/external_data_memory_port_monitor.sv ***
// Purpose: Pin sequencing checks for the external data memory port
// Assumes: Registers not rewritten during an access
// Notes:   Config and timing are mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
module xmem_monitor
  import xmem_pkg::*;
(
  input wire logic                     CLOCK,
  input wire logic                     SYS_RST,
  input wire logic [7:0]               SFR_ADDR,
  input wire logic                     SFR_WRITE,
  input wire logic [7:0]               SFR_WDATA,
  input wire logic                     MOVE_VALID,
  input wire xmem_pkg::move_req_t      MOVE_REQ,
  input wire logic                     MOVE_BUSY,
  input wire logic                     MOVE_DONE,
  input wire xmem_pkg::pins_t    [1:0] GROUP_OUT,
  input wire xmem_pkg::pins_t    [1:0] GROUP_OE_N
);
  logic [7:0] cfg, tim, lo, wd;
  logic [5:0] pins, low_run, ale_run, exp_pins;
  logic       on;
  pins_t      p;

  // Pin view, claim flag and expected length
  assign p = GROUP_OUT[0];
  assign on = ~(GROUP_OE_N[0].rd_n & GROUP_OE_N[1].rd_n);
  assign exp_pins = 6'(5 + tim[7:6] + tim[5:2] + tim[1:0]
                       + (cfg[4] ? 0 : 2 * (cfg[1:0] + 1)));

  // Register mirrors
  always_ff @(posedge CLOCK)
    if (SYS_RST)
    begin
      cfg <= CONFIG_RESET;
      tim <= TIMING_RESET;
    end
    else if (SFR_WRITE && SFR_ADDR == CONFIG_ADDR)
      cfg <= SFR_WDATA;
    else if (SFR_WRITE && SFR_ADDR == TIMING_ADDR)
      tim <= SFR_WDATA;

  // Request capture at the taking edge
  always_ff @(posedge CLOCK)
    if (MOVE_VALID && !MOVE_BUSY)
    begin
      lo <= MOVE_REQ.wide ? MOVE_REQ.pointer16[7:0] : MOVE_REQ.index_low;
      wd <= MOVE_REQ.wdata;
    end

  // Phase length counters
  always_ff @(posedge CLOCK)
  begin
    pins <= (SYS_RST || (!on && !MOVE_BUSY)) ? '0 : pins + 6'(on);
    low_run <= (SYS_RST || (p.rd_n && p.wr_n)) ? '0 : low_run + 6'd1;
    ale_run <= (!SYS_RST && p.ale && MOVE_BUSY) ? ale_run + 6'd1 : '0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_idle;
    !MOVE_BUSY |-> GROUP_OE_N == '1 && p.rd_n && p.wr_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pins claimed while idle");
  property p_group;
    GROUP_OE_N[~cfg[5]] == '1;
  endproperty
  a_group: assert property (p_group)
    else $error("unselected group driven");
  property p_both;
    p.rd_n || p.wr_n;
  endproperty
  a_both: assert property (p_both)
    else $error("read and write strobes both low");
  property p_dur;
    MOVE_DONE && pins != 6'd0 |-> pins == exp_pins;
  endproperty
  a_dur: assert property (p_dur)
    else $error("off-chip access length wrong");
  property p_width;
    $rose(p.rd_n & p.wr_n) |-> low_run == 6'(tim[5:2] + 1);
  endproperty
  a_width: assert property (p_width)
    else $error("strobe width wrong");
  property p_ale;
    $fell(p.ale) && $past(MOVE_BUSY) |-> ale_run == 6'(cfg[1:0] + 1);
  endproperty
  a_ale: assert property (p_ale)
    else $error("latch strobe high time wrong");
  property p_addr;
    MOVE_BUSY && p.ale && !cfg[4] |-> p.ad == lo
      && GROUP_OE_N[cfg[5]].ad == 8'h00;
  endproperty
  a_addr: assert property (p_addr)
    else $error("low address not on shared lines");
  property p_wdata;
    !p.wr_n |-> (cfg[4] ? p.data : p.ad) == wd;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write data wrong during strobe");
  property p_rd_off;
    !p.rd_n |-> &(cfg[4] ? (GROUP_OE_N[0].data & GROUP_OE_N[1].data)
                         : (GROUP_OE_N[0].ad & GROUP_OE_N[1].ad));
  endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("data drivers on during read");

  c_mux: cover property ($fell(p.ale) && $past(MOVE_BUSY));
  c_read: cover property (!p.rd_n);
  c_onchip: cover property (MOVE_DONE && pins == 6'd0);
endmodule // xmem_monitor

bind external_data_memory_port xmem_monitor xmem_monitor_inst (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
  .SFR_WRITE(SFR_WRITE), .SFR_WDATA(SFR_WDATA),
  .MOVE_VALID(MOVE_VALID), .MOVE_REQ(MOVE_REQ), .MOVE_BUSY(MOVE_BUSY),
  .MOVE_DONE(MOVE_DONE), .GROUP_OUT(GROUP_OUT), .GROUP_OE_N(GROUP_OE_N)
);
`default_nettype wire

// *** tb/external_data_memory_port_tb.sv ***
// Purpose: Register and external move tests of the memory port
// Assumes: One SRAM model per port group, pull-ups on data lines
// Notes:   Latency counts negedges from the taking edge to done
`timescale 1ns/1ps
`default_nettype none
module external_data_memory_port_tb;
  import xmem_pkg::*;
  logic           CLOCK;
  logic           SYS_RST;
  logic [7:0]     SFR_ADDR, SFR_WDATA, SFR_RDATA, MOVE_RDATA;
  logic           SFR_WRITE, MOVE_VALID, MOVE_BUSY, MOVE_DONE, mux, seen;
  move_req_t      MOVE_REQ;
  pins_in_t [1:0] GROUP_IN, sram_drv;
  pins_t    [1:0] GROUP_OUT, GROUP_OE_N;
  int             n_errors, n_checks, lat;

  function automatic logic [7:0] lvl(logic [7:0] dev, en_n, ext);
    return (dev & ~en_n) | (ext & en_n);
  endfunction

  external_data_memory_port external_data_memory_port_inst (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
    .SFR_WRITE(SFR_WRITE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .MOVE_VALID(MOVE_VALID), .MOVE_REQ(MOVE_REQ), .MOVE_BUSY(MOVE_BUSY),
    .MOVE_DONE(MOVE_DONE), .MOVE_RDATA(MOVE_RDATA), .GROUP_IN(GROUP_IN),
    .GROUP_OUT(GROUP_OUT), .GROUP_OE_N(GROUP_OE_N));

  // Wire levels and one SRAM per group, the high group answering slowly
  for (genvar g = 0; g < 2; g++)
  begin : grp
    assign GROUP_IN[g] = {
      lvl(GROUP_OUT[g].ad, GROUP_OE_N[g].ad, sram_drv[g].ad),
      lvl(GROUP_OUT[g].data, GROUP_OE_N[g].data, sram_drv[g].data)};
    xmem_sram #(.RD_LAT(g * 2)) sram_inst (
      .clock(CLOCK), .mux(mux), .pin(GROUP_OUT[g]),
      .oe_n(GROUP_OE_N[g]), .drv(sram_drv[g]));
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge CLOCK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WRITE = 1'b1;
    @(negedge CLOCK);
    SFR_WRITE = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge CLOCK);
    SFR_ADDR = a;
    #1;
    chk("register", {8'h00, exp}, {8'h00, SFR_RDATA});
  endtask

  task automatic mv(logic w, logic wide, logic [15:0] a, logic [7:0] d,
                    int exp_lat, logic exp_pins, logic [7:0] exp_rd);
    @(negedge CLOCK);
    MOVE_REQ = '{w, wide, a[7:0], wide ? a : ~a, d};
    MOVE_VALID = 1'b1;
    @(negedge CLOCK);
    MOVE_VALID = 1'b0;
    lat = 1;
    seen = GROUP_OE_N !== '1;
    while (MOVE_DONE !== 1'b1 && lat < 60)
    begin
      @(negedge CLOCK);
      lat++;
      seen |= GROUP_OE_N !== '1;
    end
    chk("latency", 16'(exp_lat), 16'(lat));
    chk("pins claimed", 16'(exp_pins), 16'(seen));
    if (!w)
      chk("read data", {8'h00, exp_rd}, {8'h00, MOVE_RDATA});
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Clock
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Watchdog well past the expected run length
  initial
  begin
    #20000;
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    {SYS_RST, mux} = 2'b11;
    {SFR_WRITE, MOVE_VALID} = 2'b00;
    {SFR_ADDR, SFR_WDATA} = 16'h0000;
    MOVE_REQ = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge CLOCK);
    @(negedge CLOCK);
    SYS_RST = 1'b0;
    rd(TIMING_ADDR, 8'hFF);
    rd(PAGE_ADDR, 8'h00);
    rd(CONFIG_ADDR, 8'h03);
    rd(8'hA0, 8'h00);
    wr(CONFIG_ADDR, 8'hFF);
    rd(CONFIG_ADDR, 8'h3F);
    wr(CONFIG_ADDR, 8'h03);
    mv(1'b1, 1'b1, 16'h1234, 8'h5A, 3, 1'b0, 8'h00);
    mv(1'b0, 1'b1, 16'h0234, 8'h00, 3, 1'b0, 8'h5A);
    wr(PAGE_ADDR, 8'h32);
    mv(1'b0, 1'b0, 16'h0034, 8'h00, 3, 1'b0, 8'h5A);
    mux = 1'b0;
    wr(CONFIG_ADDR, 8'h18);
    wr(PAGE_ADDR, 8'h12);
    mv(1'b1, 1'b0, 16'h0034, 8'hA5, 27, 1'b1, 8'h00);
    chk("sram low", 16'h00A5, {8'h00, grp[0].sram_inst.mem[16'h1234]});
    wr(TIMING_ADDR, 8'h00);
    mv(1'b0, 1'b1, 16'h1234, 8'h00, 6, 1'b1, 8'hA5);
    wr(PAGE_ADDR, 8'h02);
    mv(1'b0, 1'b0, 16'h0034, 8'h00, 3, 1'b0, 8'h5A);
    wr(CONFIG_ADDR, 8'h14);
    wr(PAGE_ADDR, 8'h20);
    mv(1'b1, 1'b0, 16'h0056, 8'hC3, 6, 1'b1, 8'h00);
    chk("sram low", 16'h00C3, {8'h00, grp[0].sram_inst.mem[16'hFF56]});
    mux = 1'b1;
    wr(CONFIG_ADDR, 8'h2C);
    mv(1'b1, 1'b1, 16'h0010, 8'h3C, 8, 1'b1, 8'h00);
    chk("sram high", 16'h003C, {8'h00, grp[1].sram_inst.mem[16'h0010]});
    wr(PAGE_ADDR, 8'h44);
    mv(1'b1, 1'b0, 16'h0010, 8'h77, 8, 1'b1, 8'h00);
    wr(CONFIG_ADDR, 8'h2F);
    wr(TIMING_ADDR, 8'h15);
    mv(1'b0, 1'b1, 16'hFF10, 8'h00, 20, 1'b1, 8'h77);
    mv(1'b0, 1'b1, 16'h0010, 8'h00, 20, 1'b1, 8'h3C);
    finish_test();
  end
endmodule // external_data_memory_port_tb
`default_nettype wire
